// ==== ptws_pkg.sv ====
// Register map, field layout, reset values and carrier types of the
// periodic timer. Assumes an AXI4-Lite master, 32-bit data, one word
// per register at byte address four times the register index.
//
// Functional notes
// - Postscale bits 6..3 pass one period match in every (code + 1).
// - Run bit 2 lets the count advance; when clear the count holds.
// - Prescale bits 1..0: 00 divides by 1, 01 by 4, 1x by 16.
// - Control bit 7 has no function: reads zero, writes are ignored.
`default_nettype none
package ptws_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned IDX_W  = 8;

    // Register indices
    localparam logic [IDX_W-1:0] IDX_INT_CTRL = 8'h0B;
    localparam logic [IDX_W-1:0] IDX_FLAGS    = 8'h0C;
    localparam logic [IDX_W-1:0] IDX_COUNT    = 8'h11;
    localparam logic [IDX_W-1:0] IDX_TCTRL    = 8'h12;
    localparam logic [IDX_W-1:0] IDX_ENABLES  = 8'h8C;
    localparam logic [IDX_W-1:0] IDX_PERIOD   = 8'h92;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Bit positions
    localparam int unsigned FLAG_PERIOD_BIT = 1;
    localparam int unsigned ENA_PERIOD_BIT  = 1;
    localparam int unsigned GLOBAL_IRQ_BIT  = 7;
    localparam int unsigned PERIPH_IRQ_BIT  = 6;
    localparam int unsigned TCTRL_USED_MSB  = 6;

    // Reset values
    localparam logic [7:0] RST_INT_CTRL = 8'h00;
    localparam logic [7:0] RST_COUNT    = 8'h00;
    localparam logic [6:0] RST_TCTRL    = 7'h00;
    localparam logic [7:0] RST_PERIOD   = 8'hFF;
    localparam logic       RST_FLAG     = 1'h0;
    localparam logic       RST_ENABLE   = 1'h0;

    // Prescaler terminal counts (divide minus one)
    localparam logic [3:0] PRE_LIM_1  = 4'h0;
    localparam logic [3:0] PRE_LIM_4  = 4'h3;
    localparam logic [3:0] PRE_LIM_16 = 4'hF;

    typedef struct packed {
        logic [3:0] output_postscale_sel;
        logic       timer_run;
        logic [1:0] clock_prescale_sel;
    } ptws_ctl_t;

    typedef struct packed {
        logic             en;
        logic [IDX_W-1:0] idx;
        logic [7:0]       data;
    } ptws_wr_t;

    typedef struct packed {
        logic             en;
        logic [IDX_W-1:0] idx;
    } ptws_rd_t;
endpackage
`default_nettype wire

// ==== ptws_div.sv ====
// Modulo divider: passes one input tick in every (limit + 1).
// Assumes clear is raised whenever the limit may have changed.
`timescale 1ns/1ps
`default_nettype none
module ptws_div #(
    parameter int unsigned W = 4
) (
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    input  wire logic         tick_in,
    input  wire logic         clear,
    input  wire logic [W-1:0] limit,
    output logic              wrap
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    // Clear beats a tick so a restarted divide never ends early
    always_comb begin
        wrap     = tick_in && !clear && (cnt == limit);
        next_cnt = cnt;
        if (clear || wrap) begin
            next_cnt = '0;
        end else if (tick_in) begin
            next_cnt = cnt + W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule
`default_nettype wire

// ==== ptws_axil.sv ====
// AXI4-Lite slave front end: one write and one read under way at most.
// Assumes the parent decodes indices combinationally in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module ptws_axil
    import ptws_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic                   s_axi_bvalid,
    output logic [1:0]             s_axi_bresp,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic                   s_axi_rvalid,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    input  wire logic              s_axi_rready,
    output ptws_wr_t               wr,
    output ptws_rd_t               rd,
    input  wire logic              wr_hit,
    input  wire logic              rd_hit,
    input  wire logic [7:0]        rd_data
);
    typedef enum logic {RD_IDLE, RD_RESP} ptws_rst_t;

    ptws_rst_t         rst, next_rst;
    logic              aw_full, next_aw_full, w_full, next_w_full;
    logic [ADDR_W-1:0] awaddr, next_awaddr;
    logic [7:0]        wdata, next_wdata;
    logic              wlane, next_wlane;
    logic              awready, next_awready, wready, next_wready;
    logic              bvalid, next_bvalid, arready, next_arready;
    logic              rvalid, next_rvalid;
    logic [1:0]        bresp, next_bresp, rresp, next_rresp;
    logic [31:0]       rdata, next_rdata;
    logic              fire, aw_ok, ar_ok;

    // Address and data are collected in either order, then applied
    always_comb begin
        next_aw_full = aw_full;
        next_w_full  = w_full;
        next_awaddr  = awaddr;
        next_wdata   = wdata;
        next_wlane   = wlane;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        fire  = aw_full && w_full && !bvalid;
        aw_ok = (awaddr[ADDR_W-1:IDX_W+2] == '0);
        if (s_axi_awvalid && awready) begin
            next_aw_full = 1'b1;
            next_awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready) begin
            next_w_full = 1'b1;
            next_wdata  = s_axi_wdata[7:0];
            next_wlane  = s_axi_wstrb[0];
        end
        if (fire) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (aw_ok && wr_hit) ? RESP_OKAY : RESP_DECERR;
        end else if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // Narrow registers live in lane 0; other lanes are dropped
        wr.en   = fire && aw_ok && wlane;
        wr.idx  = awaddr[IDX_W+1:2];
        wr.data = wdata;
        next_awready = !next_aw_full && !next_bvalid;
        next_wready  = !next_w_full && !next_bvalid;
    end

    // Read data is sampled at address acceptance, answered next cycle
    always_comb begin
        next_rst   = rst;
        next_rdata = rdata;
        next_rresp = rresp;
        ar_ok  = (s_axi_araddr[ADDR_W-1:IDX_W+2] == '0);
        rd.en  = s_axi_arvalid && arready && ar_ok;
        rd.idx = s_axi_araddr[IDX_W+1:2];
        case (rst)
            RD_IDLE: begin
                if (s_axi_arvalid && arready) begin
                    next_rst   = RD_RESP;
                    next_rdata = {24'h000000,
                                  (rd.en && rd_hit) ? rd_data : 8'h00};
                    next_rresp = (rd.en && rd_hit) ? RESP_OKAY
                                                   : RESP_DECERR;
                end
            end
            RD_RESP: begin
                if (s_axi_rready) begin
                    next_rst = RD_IDLE;
                end
            end
            default: next_rst = RD_IDLE;
        endcase
        next_arready = (next_rst == RD_IDLE);
        next_rvalid  = (next_rst == RD_RESP);
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst     <= RD_IDLE;
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            awaddr  <= '0;
            wdata   <= 8'h00;
            wlane   <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= RESP_OKAY;
        end else begin
            rst     <= next_rst;
            aw_full <= next_aw_full;
            w_full  <= next_w_full;
            awaddr  <= next_awaddr;
            wdata   <= next_wdata;
            wlane   <= next_wlane;
            awready <= next_awready;
            wready  <= next_wready;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            arready <= next_arready;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end
    end

    assign s_axi_awready = awready;
    assign s_axi_wready  = wready;
    assign s_axi_bvalid  = bvalid;
    assign s_axi_bresp   = bresp;
    assign s_axi_arready = arready;
    assign s_axi_rvalid  = rvalid;
    assign s_axi_rdata   = rdata;
    assign s_axi_rresp   = rresp;
endmodule
`default_nettype wire

// ==== ptws_top.sv ====
// Periodic timer with prescaler, period compare and postscaler, plus its
// interrupt flag, enable and global gating, behind an AXI4-Lite slave.
// Assumes one clock; clk_en low freezes the counting chain only.
`timescale 1ns/1ps
`default_nettype none
module ptws_top
    import ptws_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic                   s_axi_bvalid,
    output logic [1:0]             s_axi_bresp,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic                   s_axi_rvalid,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    input  wire logic              s_axi_rready,
    output logic                   irq,
    output logic                   period_match
);
    ptws_wr_t   wr;
    ptws_rd_t   rd;
    logic       wr_hit, rd_hit;
    logic [7:0] rd_data;

    // Register state
    logic [7:0] int_ctrl, next_int_ctrl;
    logic [7:0] count, next_count;
    logic [7:0] period, next_period;
    ptws_ctl_t  ctl, next_ctl;
    logic       flag, next_flag;
    logic       enable, next_enable;
    logic       next_irq, next_period_match;

    // Counting chain
    logic       tmr_clear, cnt_wr, pre_tick_in, pre_wrap;
    logic       match, post_wrap;
    logic [3:0] pre_limit;

    ptws_axil u_axil (
        .sys_clk       (sys_clk),
        .reset_n       (reset_n),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rready  (s_axi_rready),
        .wr            (wr),
        .rd            (rd),
        .wr_hit        (wr_hit),
        .rd_hit        (rd_hit),
        .rd_data       (rd_data)
    );

    function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
        case (idx)
            IDX_INT_CTRL, IDX_FLAGS, IDX_COUNT,
            IDX_TCTRL, IDX_ENABLES, IDX_PERIOD: idx_mapped = 1'b1;
            default:                            idx_mapped = 1'b0;
        endcase
    endfunction

    // Address decode and read mux; unused bits read as zero
    always_comb begin
        wr_hit  = idx_mapped(wr.idx);
        rd_hit  = idx_mapped(rd.idx);
        rd_data = 8'h00;
        case (rd.idx)
            IDX_INT_CTRL: rd_data = int_ctrl;
            IDX_FLAGS:    rd_data[FLAG_PERIOD_BIT] = flag;
            IDX_COUNT:    rd_data = count;
            IDX_TCTRL:    rd_data = {1'b0, ctl};
            IDX_ENABLES:  rd_data[ENA_PERIOD_BIT] = enable;
            IDX_PERIOD:   rd_data = period;
            default:      rd_data = 8'h00;
        endcase
    end

    // Prescale select to terminal count; both 1x codes give sixteen
    always_comb begin
        case (ctl.clock_prescale_sel)
            2'h0:    pre_limit = PRE_LIM_1;
            2'h1:    pre_limit = PRE_LIM_4;
            default: pre_limit = PRE_LIM_16;
        endcase
    end

    // A write to the count or control restarts both scalers, so a new
    // divide ratio never starts from a stale partial count
    always_comb begin
        cnt_wr      = wr.en && (wr.idx == IDX_COUNT);
        tmr_clear   = cnt_wr || (wr.en && (wr.idx == IDX_TCTRL));
        pre_tick_in = clk_en && ctl.timer_run;
        match       = pre_wrap && (count == period);
    end

    ptws_div #(.W(4)) u_pre (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .tick_in (pre_tick_in),
        .clear   (tmr_clear),
        .limit   (pre_limit),
        .wrap    (pre_wrap)
    );

    // Postscaler counts period matches, not prescaled ticks
    ptws_div #(.W(4)) u_post (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .tick_in (match),
        .clear   (tmr_clear),
        .limit   (ctl.output_postscale_sel),
        .wrap    (post_wrap)
    );

    // Register writes; a software write to the count beats an increment
    always_comb begin
        next_int_ctrl = int_ctrl;
        next_count    = count;
        next_period   = period;
        next_ctl      = ctl;
        next_enable   = enable;
        if (cnt_wr) begin
            next_count = wr.data;
        end else if (pre_wrap) begin
            next_count = match ? 8'h00 : count + 8'h01;
        end
        if (wr.en) begin
            case (wr.idx)
                IDX_INT_CTRL: next_int_ctrl = wr.data;
                IDX_TCTRL:    next_ctl = wr.data[TCTRL_USED_MSB:0];
                IDX_ENABLES:  next_enable = wr.data[ENA_PERIOD_BIT];
                IDX_PERIOD:   next_period = wr.data;
                default:      next_period = period;
            endcase
        end
    end

    // Sticky flag: a wrap in the same cycle as the clearing read wins
    always_comb begin
        next_flag = flag;
        if (post_wrap) begin
            next_flag = 1'b1;
        end else if (rd.en && (rd.idx == IDX_FLAGS)) begin
            next_flag = 1'b0;
        end
        next_irq = next_flag && next_enable
                   && next_int_ctrl[GLOBAL_IRQ_BIT]
                   && next_int_ctrl[PERIPH_IRQ_BIT];
        next_period_match = match;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            int_ctrl     <= RST_INT_CTRL;
            count        <= RST_COUNT;
            period       <= RST_PERIOD;
            ctl          <= RST_TCTRL;
            flag         <= RST_FLAG;
            enable       <= RST_ENABLE;
            irq          <= 1'b0;
            period_match <= 1'b0;
        end else begin
            int_ctrl     <= next_int_ctrl;
            count        <= next_count;
            period       <= next_period;
            ctl          <= next_ctl;
            flag         <= next_flag;
            enable       <= next_enable;
            irq          <= next_irq;
            period_match <= next_period_match;
        end
    end

    // Helper counters that only the checks below read
    logic [3:0] gap, next_gap, match_cnt, next_match_cnt;

    always_comb begin
        next_gap       = gap;
        next_match_cnt = match_cnt;
        if (tmr_clear || pre_wrap) begin
            next_gap = 4'h0;
        end else if (pre_tick_in) begin
            next_gap = gap + 4'h1;
        end
        if (tmr_clear || post_wrap) begin
            next_match_cnt = 4'h0;
        end else if (match) begin
            next_match_cnt = match_cnt + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gap       <= 4'h0;
            match_cnt <= 4'h0;
        end else begin
            gap       <= next_gap;
            match_cnt <= next_match_cnt;
        end
    end

    chk_post_ratio: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        post_wrap |-> match_cnt == ctl.output_postscale_sel)
        else $error("postscaler wrapped at the wrong match count");

    chk_stop_holds: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (!ctl.timer_run && !cnt_wr) |=> $stable(count))
        else $error("count moved while the timer was stopped");

    chk_pre_ratio: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        pre_wrap |-> gap == pre_limit)
        else $error("prescaler passed a tick at the wrong ratio");

    chk_pre_one: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (pre_tick_in && ctl.clock_prescale_sel == 2'h0 && !tmr_clear)
        |-> pre_wrap)
        else $error("divide by one missed a tick");

    chk_msb_zero: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (rd.en && rd.idx == IDX_TCTRL) |=> s_axi_rdata[7] == 1'b0)
        else $error("unused control bit read back as one");

    chk_wrap_zero: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (match && !cnt_wr) |=> (count == 8'h00)
        && period_match)
        else $error("count did not return to zero after a match");

    chk_flag_irq: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (post_wrap && enable && int_ctrl[GLOBAL_IRQ_BIT]
         && int_ctrl[PERIPH_IRQ_BIT] && !wr.en) |=> flag && irq)
        else $error("postscaler wrap did not raise flag and irq");

    // With a postscale of one every match must reach the flag
    chk_post_one: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (match && ctl.output_postscale_sel == 4'h0) |-> post_wrap)
        else $error("postscale of one missed a match");

    // Clock enable low must freeze the count as hard as a stop does
    chk_freeze_holds: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (!clk_en && !cnt_wr) |=> $stable(count))
        else $error("count moved while the clock enable was low");

    // A clearing read loses only to a new event in the same cycle
    chk_flag_clear: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (rd.en && rd.idx == IDX_FLAGS && !post_wrap) |=> !flag)
        else $error("reading the flags did not clear the flag");

    // The interrupt is a pure level of its four stored gates
    chk_irq_gated: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        irq == (flag && enable && int_ctrl[GLOBAL_IRQ_BIT]
                && int_ctrl[PERIPH_IRQ_BIT]))
        else $error("irq level disagrees with its gates");

    // Bus answers must stand until the master takes them
    chk_bresp_hold: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (s_axi_bvalid && !s_axi_bready)
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before it was taken");

    chk_rdata_hold: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (s_axi_rvalid && !s_axi_rready)
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before it was taken");
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the periodic timer: register map, scalers,
// run control and the interrupt path, driven over AXI4-Lite.
// Assumes the design's package and modules are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    miscompares++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module testbench;
    import ptws_pkg::*;
    logic              sys_clk, reset_n, clk_en;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic              s_axi_rready, irq, period_match;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    int                miscompares, n_tests, cyc;
    logic [31:0]       seed, rd;
    logic [7:0]        p, v;
    ptws_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bresp(s_axi_bresp), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rready(s_axi_rready), .irq(irq),
        .period_match(period_match));
    // 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Repeatable pseudo-random source
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [11:0] ba(input logic [IDX_W-1:0] i);
        return {2'h0, i, 2'h0};
    endfunction
    // Divide ratio of each prescale code; upper bit set means sixteen
    function automatic int pdiv(input logic [1:0] c);
        return c[1] ? 16 : (c[0] ? 4 : 1);
    endfunction
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Hang guard: run should need far fewer cycles than this
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            finish_test();
        end
    end
    // Write: address and data offered together, each dropped once taken
    task automatic axw(input logic [IDX_W-1:0] i, input logic [7:0] d,
                       input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_awaddr <= ba(i);
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        `CHK("bresp", er, s_axi_bresp)
        s_axi_bready <= 1'b0;
    endtask
    // Read: rready held until the answer is sampled
    task automatic axr(input logic [IDX_W-1:0] i, input logic [1:0] er,
                       output logic [31:0] d);
        @(posedge sys_clk);
        s_axi_araddr <= ba(i);
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        d = s_axi_rdata;
        `CHK("rresp", er, s_axi_rresp)
        s_axi_rready <= 1'b0;
    endtask
    // Skip one partial period, then time one whole match interval
    task automatic meas(input int e);
        int n;
        n = 0;
        @(posedge sys_clk);
        while (period_match !== 1'b1) @(posedge sys_clk);
        do begin
            @(posedge sys_clk);
            n++;
        end while (period_match !== 1'b1);
        `CHK("interval", e, n)
    endtask
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        clk_en = 1'b1;
        reset_n = 1'b0;
        seed = 32'h61;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        // Reset values, then an unmapped place
        axr(IDX_COUNT, RESP_OKAY, rd);
        `CHK("count rst", 32'h00, rd)
        axr(IDX_TCTRL, RESP_OKAY, rd);
        `CHK("tctrl rst", 32'h00, rd)
        axr(IDX_PERIOD, RESP_OKAY, rd);
        `CHK("period rst", 32'hFF, rd)
        axr(IDX_FLAGS, RESP_OKAY, rd);
        `CHK("flags rst", 32'h00, rd)
        axr(8'h01, RESP_DECERR, rd);
        `CHK("unmapped", 32'h00, rd)
        axw(8'h01, 8'hAA, RESP_DECERR);
        s_axi_wstrb <= 4'hE;
        axw(IDX_PERIOD, 8'h12, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        axr(IDX_PERIOD, RESP_OKAY, rd);
        `CHK("no lane0", 32'hFF, rd)
        $display("test reset_map done");
        // Top control bit reads zero whatever is written
        seed = xs(seed);
        axw(IDX_TCTRL, 8'hFB, RESP_OKAY);
        axr(IDX_TCTRL, RESP_OKAY, rd);
        `CHK("tctrl b7", 32'h7B, rd)
        axw(IDX_TCTRL, seed[7:0] & 8'hFB, RESP_OKAY);
        axr(IDX_TCTRL, RESP_OKAY, rd);
        `CHK("tctrl rnd", {24'h0, seed[7:0] & 8'h7B}, rd)
        $display("test ctrl_bit7 done");
        // Stopped count holds; frozen clock enable also holds it
        axw(IDX_COUNT, 8'h55, RESP_OKAY);
        repeat (20) @(posedge sys_clk);
        axr(IDX_COUNT, RESP_OKAY, rd);
        `CHK("count stop", 32'h55, rd)
        clk_en <= 1'b0;
        axw(IDX_TCTRL, 8'h04, RESP_OKAY);
        repeat (10) @(posedge sys_clk);
        axr(IDX_COUNT, RESP_OKAY, rd);
        `CHK("count frozen", 32'h55, rd)
        clk_en <= 1'b1;
        repeat (5) @(posedge sys_clk);
        axr(IDX_COUNT, RESP_OKAY, rd);
        `CHK("count runs", 32'h5B, rd)
        $display("test run_ctrl done");
        // Every prescale code with short periods, zero period included
        for (int c = 0; c < 4; c++) begin
            seed = xs(seed);
            p = (c == 0) ? 8'h00 : {5'h0, seed[2:0]};
            axw(IDX_PERIOD, p, RESP_OKAY);
            axw(IDX_COUNT, 8'h00, RESP_OKAY);
            axw(IDX_TCTRL, {6'h01, c[1:0]}, RESP_OKAY);
            meas(pdiv(c[1:0]) * (p + 1));
        end
        $display("test prescale done");
        // Postscale: matches until the interrupt, corners and random
        axw(IDX_INT_CTRL, 8'hC0, RESP_OKAY);
        axw(IDX_ENABLES, 8'h02, RESP_OKAY);
        for (int k = 0; k < 4; k++) begin
            int m;
            seed = xs(seed);
            v = (k == 0) ? 8'h00 : ((k == 1) ? 8'h0F : {4'h0, seed[3:0]});
            axw(IDX_TCTRL, 8'h00, RESP_OKAY);
            axw(IDX_PERIOD, 8'h02, RESP_OKAY);
            axr(IDX_FLAGS, RESP_OKAY, rd);
            axw(IDX_COUNT, 8'h00, RESP_OKAY);
            `CHK("irq idle", 1'b0, irq)
            axw(IDX_TCTRL, {v[4:0], 3'h4}, RESP_OKAY);
            m = 0;
            do begin
                @(posedge sys_clk);
                if (period_match === 1'b1) m++;
            end while (irq !== 1'b1);
            `CHK("post matches", v + 1, m)
        end
        // Mask, unmask, then read-to-clear with the timer stopped
        axw(IDX_TCTRL, 8'h00, RESP_OKAY);
        axw(IDX_ENABLES, 8'h00, RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        `CHK("irq masked", 1'b0, irq)
        axw(IDX_ENABLES, 8'h02, RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        `CHK("irq unmask", 1'b1, irq)
        axr(IDX_FLAGS, RESP_OKAY, rd);
        `CHK("flag set", 32'h02, rd)
        axr(IDX_FLAGS, RESP_OKAY, rd);
        `CHK("flag clr", 32'h00, rd)
        `CHK("irq clr", 1'b0, irq)
        $display("test postscale_irq done");
        finish_test();
    end
endmodule
`default_nettype wire
